// ===== design/ltir_countdown.sv
/*
  Reloading countdown timer stepped on both edges of the crystal reference.
  Assumes xtal_ref is synchronous to sys_clk and slower than half its rate.
*/
`timescale 1ns/1ps
module ltir_countdown (
  // Clock and reset
  input  logic                         sys_clk,
  input  logic                         reset_n,
  // Reference and configuration
  input  logic                         xtal_ref,
  input  ltir_pkg::ltir_cd_cfg_t       cd_cfg,
  // Software pulses
  input  logic                         reload_pulse,
  input  logic                         clear_pulse,
  // State
  output logic [ltir_pkg::CD_LOAD_W-1:0] cd_count,
  output logic                         cd_flag
);
  import ltir_pkg::*;

  logic                 xtal_prev;
  logic                 xtal_edge;
  logic                 cd_step;
  logic                 cd_cross;
  logic [CD_LOAD_W-1:0] next_cd_count;
  logic                 next_cd_flag;

  // Either edge of the reference steps an enabled timer
  assign xtal_edge     = xtal_ref ^ xtal_prev;                        // R11
  assign cd_step       = xtal_edge && cd_cfg.enable;                  // R11 R13
  assign cd_cross      = cd_step && (cd_count == '0);                 // R12
  assign next_cd_count = reload_pulse ? cd_cfg.load :                 // R18
                         cd_cross     ? cd_cfg.load :                 // R12
                         cd_step      ? cd_count - 1'b1 :
                         cd_count;
  // Flag: a crossing wins over a clear in the same cycle
  assign next_cd_flag  = (cd_cross && cd_cfg.irq_en) ? 1'b1 :         // R14 R17 R20
                         clear_pulse                 ? 1'b0 :         // R16
                         cd_flag;

  // Timer registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_prev <= 1'b0;
      cd_count  <= '0;
      cd_flag   <= 1'b0;
    end else begin
      xtal_prev <= xtal_ref;
      cd_count  <= next_cd_count;
      cd_flag   <= next_cd_flag;
    end
  end

endmodule

// ===== design/ltir_pkg.sv
/*
  Shared constants and carrier types for the local timer and interrupt routing block.
  Assumes a single 100 MHz system clock and a register port that is a plain
  address, data and strobe port with read data one cycle after the strobe.
*/
package ltir_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PERF_SET     = 8'h00;
  localparam logic [7:0] OFS_PERF_CLEAR   = 8'h04;
  localparam logic [7:0] OFS_PERI_ROUTE   = 8'h08;
  localparam logic [7:0] OFS_QUIET_TIME   = 8'h0C;
  localparam logic [7:0] OFS_CD_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_CD_IRQ_CTRL  = 8'h14;

  // Core count and field layout
  localparam int         NUM_CORES        = 4;
  localparam int         PERF_W           = 8;
  localparam int         PERF_FAST_LSB    = 4;
  localparam int         PERF_NORM_LSB    = 0;
  localparam int         KEY_MSB          = 31;
  localparam int         KEY_LSB          = 24;
  localparam logic [7:0] ROUTE_KEY        = 8'h01;
  localparam int         ROUTE_W          = 3;
  localparam int         QUIET_EN_BIT     = 20;
  localparam int         QUIET_TIME_W     = 20;
  localparam int         QUIET_CNT_W      = 24;
  localparam int         CD_FLAG_BIT      = 31;
  localparam int         CD_IRQ_EN_BIT    = 29;
  localparam int         CD_EN_BIT        = 28;
  localparam int         CD_LOAD_W        = 28;
  localparam int         CD_CLEAR_BIT     = 31;
  localparam int         CD_RELOAD_BIT    = 30;

  // Quiet counter load is unit times the programmed time plus an extra
  localparam logic [23:0] QUIET_UNIT      = 24'h000010;
  localparam logic [23:0] QUIET_EXTRA     = 24'h00000F;

  // Reset values
  localparam logic [7:0]  PERF_RST        = 8'h00;
  localparam logic [2:0]  ROUTE_RST       = 3'h0;
  localparam logic [20:0] QUIET_RST       = 21'h000000;
  localparam logic [29:0] CD_CTRL_RST     = 30'h00000000;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ltir_bus_req_t;

  // Countdown timer configuration
  typedef struct packed {
    logic                 irq_en;
    logic                 enable;
    logic [CD_LOAD_W-1:0] load;
  } ltir_cd_cfg_t;

endpackage

// ===== design/ltir_quiet.sv
/*
  Bus-quiet counter: reloads while bus transactions are outstanding and counts
  down while the bus is idle. Assumes bus_busy is synchronous to sys_clk.
*/
`timescale 1ns/1ps
module ltir_quiet (
  // Clock and reset
  input  logic                          sys_clk,
  input  logic                          reset_n,
  // Bus activity and programmed time
  input  logic                          bus_busy,
  input  logic [ltir_pkg::QUIET_TIME_W-1:0] quiet_time,
  // State
  output logic [ltir_pkg::QUIET_CNT_W-1:0]  quiet_count,
  output logic                          quiet_expired
);
  import ltir_pkg::*;

  logic [QUIET_CNT_W-1:0] quiet_load;
  logic [QUIET_CNT_W-1:0] next_quiet_count;

  // Load value and next count
  assign quiet_load       = (QUIET_CNT_W'(quiet_time) * QUIET_UNIT) + QUIET_EXTRA; // R7 R10
  assign next_quiet_count = bus_busy           ? quiet_load :                     // R7
                            (quiet_count != '0) ? quiet_count - 1'b1 :            // R8
                            quiet_count;
  assign quiet_expired    = (quiet_count == '0);

  // Counter register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_count <= QUIET_EXTRA;
    end else begin
      quiet_count <= next_quiet_count;
    end
  end

endmodule

// ===== design/ltir_top.sv
/*
  Local timer and interrupt routing for a four-core cluster: performance
  monitor routing word, local timer routing, bus-quiet timer and countdown timer.
  Assumes all inputs synchronous to sys_clk and a register port whose master
  never issues read and write strobes together.
*/
// Implementation choices: the address-and-strobe port and the register offsets.
// Notes on behaviour
// R1 - Writing one to a clear-view bit clears that routing bit; zeros keep it.
// R2 - Fast field bit N sends core N monitor request to its fast pin.
// R3 - Normal field bit N sends core N monitor request to its normal pin.
// R4 - With both bits set, the request goes to the fast pin only.
// R5 - Timer route field updates only when write bits 31:24 equal 0x01.
// R6 - Route 0-3 drives normal pin of cores 0-3; 4-7 the fast pins.
// R7 - Quiet counter loads sixteen times quiet time plus 15 while bus busy.
// R8 - Quiet counter decrements each clock while no transaction outstanding.
// R9 - Quiet counter at zero with bit 20 set raises core 0 normal pin.
// R10 - Quiet time field is bits 19:0 in units of sixteen clocks.
// R11 - Enabled local timer decrements on both reference clock edges.
// R12 - At zero the timer reloads from bits 27:0 and keeps counting.
// R13 - Timer enable bit 28 low stops counting and interrupt requests.
// R14 - Interrupt enable bit 29 makes each zero crossing raise a request.
// R15 - Control bit 31 reads the pending timer request, read only.
// R16 - Writing one to interrupt bit 31 clears the request; self-clearing.
// R17 - A crossing in the clear cycle beats the clear; request stays.
// R18 - Writing one to interrupt bit 30 loads the timer now; self-clearing.
// R19 - Writing one to a set-view bit sets that routing bit; zeros keep it.
// R20 - Timer request holds until cleared and drives only the routed pin.
`timescale 1ns/1ps
module ltir_top (
  // Clock and reset
  input  logic                          sys_clk,
  input  logic                          reset_n,
  // Register port
  input  ltir_pkg::ltir_bus_req_t       bus_req,
  output logic [31:0]                   bus_rdata,
  // Cluster inputs
  input  logic [ltir_pkg::NUM_CORES-1:0] perf_monitor_request,
  input  logic                          bus_busy,
  input  logic                          xtal_ref,
  // Core interrupt pins
  output logic [ltir_pkg::NUM_CORES-1:0] core_normal_int,
  output logic [ltir_pkg::NUM_CORES-1:0] core_fast_int
);
  import ltir_pkg::*;

  // Decodes a three-bit route into one enable per destination pin
  function automatic logic [7:0] route_decode(input logic [ROUTE_W-1:0] route);
    logic [7:0] hot;
    hot        = 8'h00;
    hot[route] = 1'b1;
    return hot;
  endfunction

  // Software-visible state
  logic [PERF_W-1:0]       perf_route;
  logic [ROUTE_W-1:0]      timer_route;
  logic [20:0]             quiet_ctrl;
  logic [29:0]             cd_ctrl;
  // Next values
  logic [PERF_W-1:0]       next_perf_route;
  logic [ROUTE_W-1:0]      next_timer_route;
  logic [20:0]             next_quiet_ctrl;
  logic [29:0]             next_cd_ctrl;
  logic [31:0]             next_rdata;
  // Access decode
  logic                    wr_perf_set;
  logic                    wr_perf_clear;
  logic                    wr_route;
  logic                    route_key_ok;
  logic                    wr_quiet;
  logic                    wr_cd_ctrl;
  logic                    wr_cd_irq;
  logic                    hit_perf;
  logic                    hit_route;
  logic                    hit_quiet;
  logic                    hit_cd_ctrl;
  // Sub-block wiring
  ltir_cd_cfg_t            cd_cfg;
  logic                    cd_reload;
  logic                    cd_clear;
  logic                    cd_flag;
  logic                    quiet_expired;
  logic                    quiet_req;
  logic [7:0]              timer_pins;
  logic [PERF_W-1:0]       perf_fast_mask;
  logic [PERF_W-1:0]       perf_norm_mask;
  logic [NUM_CORES-1:0]    next_normal;
  logic [NUM_CORES-1:0]    next_fast;

  // Write strobes per register
  assign wr_perf_set   = bus_req.wr && (bus_req.addr == OFS_PERF_SET);
  assign wr_perf_clear = bus_req.wr && (bus_req.addr == OFS_PERF_CLEAR);
  assign wr_route      = bus_req.wr && (bus_req.addr == OFS_PERI_ROUTE);
  assign wr_quiet      = bus_req.wr && (bus_req.addr == OFS_QUIET_TIME);
  assign wr_cd_ctrl    = bus_req.wr && (bus_req.addr == OFS_CD_CONTROL);
  assign wr_cd_irq     = bus_req.wr && (bus_req.addr == OFS_CD_IRQ_CTRL);
  assign route_key_ok  = (bus_req.wdata[KEY_MSB:KEY_LSB] == ROUTE_KEY);

  // Address hits for reads
  assign hit_perf      = (bus_req.addr == OFS_PERF_SET) ||
                         (bus_req.addr == OFS_PERF_CLEAR);
  assign hit_route     = (bus_req.addr == OFS_PERI_ROUTE);
  assign hit_quiet     = (bus_req.addr == OFS_QUIET_TIME);
  assign hit_cd_ctrl   = (bus_req.addr == OFS_CD_CONTROL);

  // Routing word: set view ORs ones in, clear view masks ones out
  assign next_perf_route =
    wr_perf_set   ? (perf_route | bus_req.wdata[PERF_W-1:0]) :            // R19
    wr_perf_clear ? (perf_route & ~bus_req.wdata[PERF_W-1:0]) :           // R1
    perf_route;

  // Timer route changes only with the key in the top byte
  assign next_timer_route = (wr_route && route_key_ok) ?                   // R5
                            bus_req.wdata[ROUTE_W-1:0] : timer_route;

  // Quiet time and enable
  assign next_quiet_ctrl = wr_quiet ? bus_req.wdata[20:0] : quiet_ctrl;   // R10

  // Countdown control holds enable, interrupt enable and load value
  assign next_cd_ctrl = wr_cd_ctrl ? bus_req.wdata[29:0] : cd_ctrl;

  // Self-clearing command pulses
  assign cd_clear  = wr_cd_irq && bus_req.wdata[CD_CLEAR_BIT];             // R16
  assign cd_reload = wr_cd_irq && bus_req.wdata[CD_RELOAD_BIT];            // R18

  // Read data, zero for write-only views and unmapped addresses
  assign next_rdata =
    !bus_req.rd ? 32'h00000000 :
    hit_perf    ? {24'h000000, perf_route} :
    hit_route   ? {29'h00000000, timer_route} :
    hit_quiet   ? {11'h000, quiet_ctrl} :
    hit_cd_ctrl ? {cd_flag, 1'b0, cd_ctrl} :                                // R15
    32'h00000000;

  // Software register file
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      perf_route  <= PERF_RST;
      timer_route <= ROUTE_RST;
      quiet_ctrl  <= QUIET_RST;
      cd_ctrl     <= CD_CTRL_RST;
      bus_rdata   <= 32'h00000000;
    end else begin
      perf_route  <= next_perf_route;
      timer_route <= next_timer_route;
      quiet_ctrl  <= next_quiet_ctrl;
      cd_ctrl     <= next_cd_ctrl;
      bus_rdata   <= next_rdata;
    end
  end

  // Countdown configuration carrier
  assign cd_cfg.irq_en = cd_ctrl[CD_IRQ_EN_BIT];                          // R14
  assign cd_cfg.enable = cd_ctrl[CD_EN_BIT];                              // R13
  assign cd_cfg.load   = cd_ctrl[CD_LOAD_W-1:0];                          // R12

  // Bus-quiet counter
  ltir_quiet u_quiet (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .bus_busy      (bus_busy),
    .quiet_time    (quiet_ctrl[QUIET_TIME_W-1:0]),
    .quiet_count   (),
    .quiet_expired (quiet_expired)
  );

  // Local countdown timer
  ltir_countdown u_countdown (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .xtal_ref     (xtal_ref),
    .cd_cfg       (cd_cfg),
    .reload_pulse (cd_reload),
    .clear_pulse  (cd_clear),
    .cd_count     (),
    .cd_flag      (cd_flag)
  );

  // Quiet request only when enabled
  assign quiet_req = quiet_expired && quiet_ctrl[QUIET_EN_BIT];            // R9

  // Timer request goes to the one pin its route selects
  assign timer_pins = cd_flag ? route_decode(timer_route) : 8'h00;        // R6 R20

  // Monitor routing masks, fast overrides normal
  assign perf_fast_mask = perf_route >> PERF_FAST_LSB;
  assign perf_norm_mask = perf_route >> PERF_NORM_LSB;

  // Per-core pin merge
  genvar core;
  generate
    for (core = 0; core < NUM_CORES; core++) begin : g_core
      assign next_fast[core] =
        (perf_monitor_request[core] && perf_fast_mask[core]) ||             // R2
        timer_pins[NUM_CORES + core];                                       // R6
      assign next_normal[core] =
        (perf_monitor_request[core] && perf_norm_mask[core] &&              // R3
         !perf_fast_mask[core]) ||                                          // R4
        timer_pins[core] ||                                                 // R6
        ((core == 0) && quiet_req);                                         // R9
    end
  endgenerate

  // Registered interrupt pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_normal_int <= '0;
      core_fast_int   <= '0;
    end else begin
      core_normal_int <= next_normal;
      core_fast_int   <= next_fast;
    end
  end

endmodule

// ===== test/ltir_cores.sv
/*
  Model of the four cores: raises monitor requests on command.
  Assumes the bench drives perf_cmd and that requests are plain levels.
*/
`timescale 1ns/1ps
module ltir_cores (
  // Clock
  input  wire logic [0:0]                      sys_clk,
  // Bench command and core interrupt pins
  input  wire logic [ltir_pkg::NUM_CORES-1:0]  perf_cmd,
  input  wire logic [ltir_pkg::NUM_CORES-1:0]  core_normal_int,
  input  wire logic [ltir_pkg::NUM_CORES-1:0]  core_fast_int,
  // Monitor requests of the cores
  output logic      [ltir_pkg::NUM_CORES-1:0]  perf_monitor_request
);
  import ltir_pkg::*;
  // Requests change just after an edge, as core logic would
  always_ff @(posedge sys_clk) begin
    perf_monitor_request <= perf_cmd;
  end
endmodule

// ===== test/ltir_monitor.sv
/*
  Checker for the register port of the local timer and routing block.
  Assumes it is bound to ltir_top and that strobes are one cycle long.
*/
`timescale 1ns/1ps
module ltir_monitor (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  // Register port
  input wire ltir_pkg::ltir_bus_req_t bus_req,
  input wire logic [31:0]             bus_rdata
);
  import ltir_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Read data stands only in the slot after a read
  property p_idle; !$past(bus_req.rd) |-> bus_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");

  // Set view and clear view act on the same word
  property p_set; (bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata[7:0] == 8'hFF) ##1
    !bus_req.wr ##1 (bus_req.rd && bus_req.addr inside {8'h00, 8'h04}) |=>
    bus_rdata == 32'hFF; endproperty
  a_set: assert property (p_set) else $error("set view lost bits");
  property p_clr; (bus_req.wr && bus_req.addr == 8'h04 && bus_req.wdata[7:0] == 8'hFF) ##1
    !bus_req.wr ##1 (bus_req.rd && bus_req.addr inside {8'h00, 8'h04}) |=>
    bus_rdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear view kept bits");

  // Keyed route write lands in the route field
  property p_key; (bus_req.wr && bus_req.addr == 8'h08 && bus_req.wdata[31:24] == 8'h01) ##1
    !bus_req.wr ##1 (bus_req.rd && bus_req.addr == 8'h08) |=>
    bus_rdata == {29'h0, $past(bus_req.wdata[2:0], 3)};
  endproperty
  a_key: assert property (p_key) else $error("keyed route write lost");

  // Field widths and the zero control bit 30 seen on reads
  property p_route; $past(bus_req.rd && bus_req.addr == 8'h08) |-> bus_rdata[31:3] == 29'h0;
  endproperty
  a_route: assert property (p_route) else $error("route read too wide");
  property p_quiet; $past(bus_req.rd && bus_req.addr == 8'h0C) |-> bus_rdata[31:21] == 11'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet read too wide");
  property p_perf; $past(bus_req.rd && bus_req.addr == 8'h04) |-> bus_rdata[31:8] == 24'h0;
  endproperty
  a_perf: assert property (p_perf) else $error("routing word too wide");
  property p_res; $past(bus_req.rd && bus_req.addr == 8'h10) |-> bus_rdata[30] == 1'b0;
  endproperty
  a_res: assert property (p_res) else $error("control bit 30 set");

  // Self-clearing command bits read back as zero
  property p_cmd; $past(bus_req.rd && bus_req.addr == 8'h14) |-> bus_rdata == 32'h0; endproperty
  a_cmd: assert property (p_cmd) else $error("command bits held");
endmodule

// ===== test/tb_ltir_top.sv
/*
  Self-checking bench for ltir_top: routing word, route key, quiet timer, countdown.
  Assumes the package, design, checker and core model are compiled first.
*/
`timescale 1ns/1ps
module tb_ltir_top;
  import ltir_pkg::*;
  logic          sys_clk  = 1'b0;
  logic          reset_n  = 1'b0;
  ltir_bus_req_t bus_req  = '0;
  logic [31:0]   bus_rdata;
  logic [3:0]    perf_monitor_request;
  logic [3:0]    perf_cmd = 4'h0;
  logic          bus_busy = 1'b1;
  logic          xtal_ref = 1'b0;
  logic [3:0]    core_normal_int;
  logic [3:0]    core_fast_int;
  logic [31:0]   rv;
  int            n_fail = 0;
  int            checks_done = 0;
  int            cycles = 0;

  // Clock and run ceiling
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  ltir_top i_ltir_top (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .perf_monitor_request(perf_monitor_request),
    .bus_busy(bus_busy), .xtal_ref(xtal_ref), .core_normal_int(core_normal_int),
    .core_fast_int(core_fast_int));
  ltir_cores i_ltir_cores (.sys_clk(sys_clk), .perf_cmd(perf_cmd),
    .core_normal_int(core_normal_int), .core_fast_int(core_fast_int),
    .perf_monitor_request(perf_monitor_request));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register access; read data is taken in the slot after the strobe
  task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 rv = bus_rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    access(a, 32'h0, 1'b0);
    chk($sformatf("register %h", a), rv, exp);
  endtask

  task automatic pins(input logic [3:0] n, input logic [3:0] f);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("normal pins", {28'h0, core_normal_int}, {28'h0, n});
    chk("fast pins", {28'h0, core_fast_int}, {28'h0, f});
  endtask

  // Each reference change is one timer step
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      xtal_ref <= ~xtal_ref;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rd(a[7:0], 32'h0);
    access(8'h0C, 32'hFFFFFFFF, 1'b1);
    rd(8'h0C, 32'h001FFFFF);
    $display("test registers done");
    access(8'h00, 32'hFFFFFF36, 1'b1);
    rd(8'h00, 32'h36);
    @(posedge sys_clk) perf_cmd <= 4'hF;
    pins(4'h4, 4'h3);
    access(8'h04, 32'h12, 1'b1);
    rd(8'h04, 32'h24);
    pins(4'h4, 4'h2);
    access(8'h00, 32'hFF, 1'b1);
    rd(8'h04, 32'hFF);
    pins(4'h0, 4'hF);
    access(8'h04, 32'hFF, 1'b1);
    rd(8'h00, 32'h0);
    pins(4'h0, 4'h0);
    @(posedge sys_clk) perf_cmd <= 4'h0;
    $display("test routing word done");
    access(8'h0C, 32'h00100001, 1'b1);
    @(posedge sys_clk) bus_busy <= 1'b0;
    repeat (30) @(posedge sys_clk);
    #1 chk("quiet pin early", {31'h0, core_normal_int[0]}, 32'h0);
    repeat (3) @(posedge sys_clk);
    #1 chk("quiet pin", {31'h0, core_normal_int[0]}, 32'h1);
    @(posedge sys_clk) bus_busy <= 1'b1;
    pins(4'h0, 4'h0);
    access(8'h0C, 32'h1, 1'b1);
    @(posedge sys_clk) bus_busy <= 1'b0;
    repeat (40) @(posedge sys_clk);
    pins(4'h0, 4'h0);
    @(posedge sys_clk) bus_busy <= 1'b1;
    $display("test quiet timer done");
    access(8'h08, 32'h5, 1'b1);
    rd(8'h08, 32'h0);
    access(8'h08, 32'h01000005, 1'b1);
    rd(8'h08, 32'h5);
    access(8'h10, 32'h30000003, 1'b1);
    access(8'h14, 32'h40000000, 1'b1);
    step(3);
    pins(4'h0, 4'h0);
    step(1);
    pins(4'h0, 4'h2);
    rd(8'h10, 32'hB0000003);
    step(1);
    pins(4'h0, 4'h2);
    access(8'h14, 32'h80000000, 1'b1);
    rd(8'h10, 32'h30000003);
    rd(8'h14, 32'h0);
    step(2);
    pins(4'h0, 4'h0);
    for (int r = 0; r < 8; r++) begin
      access(8'h08, {8'h01, 21'h0, 3'(r)}, 1'b1);
      step(1);
      pins(r < 4 ? 4'(1 << r) : 4'h0, r < 4 ? 4'h0 : 4'(1 << (r - 4)));
      access(8'h14, 32'h80000000, 1'b1);
      step(3);
    end
    // Clear write and zero crossing sampled at one edge: the crossing wins
    @(posedge sys_clk);
    bus_req  <= '{addr: 8'h14, wdata: 32'h80000000, wr: 1'b1, rd: 1'b0};
    xtal_ref <= ~xtal_ref;
    @(posedge sys_clk);
    bus_req  <= '0;
    pins(4'h0, 4'h8);
    rd(8'h10, 32'hB0000003);
    access(8'h14, 32'h80000000, 1'b1);
    // Crossings with the interrupt enable low, and steps with the timer enable low, raise nothing
    access(8'h10, 32'h10000003, 1'b1);
    step(5);
    pins(4'h0, 4'h0);
    rd(8'h10, 32'h10000003);
    access(8'h10, 32'h20000003, 1'b1);
    step(8);
    pins(4'h0, 4'h0);
    rd(8'h10, 32'h20000003);
    $display("test countdown done");
    stop_test();
  end
endmodule

bind ltir_top ltir_monitor i_ltir_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata));
